// >>> logic/sce_consts.svh
// Purpose: constants of the serial character engine
// Assumes: 8-bit register port, 3-bit register index
// Notes:   offsets are register indices on the plain port
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH

`define SCE_OFF_BDH      3'h0
`define SCE_OFF_BDL      3'h1
`define SCE_OFF_CR1      3'h2
`define SCE_OFF_CR2      3'h3
`define SCE_OFF_SR1      3'h4
`define SCE_OFF_DH       3'h6
`define SCE_OFF_DL       3'h7

`define SCE_C1_PTYPE     0
`define SCE_C1_PAR       1
`define SCE_C1_LBRK      3
`define SCE_C1_CHAR9     4
`define SCE_C2_BRK       0
`define SCE_C2_RXON      2
`define SCE_C2_TXON      3
`define SCE_C2_RXIE      5
`define SCE_C2_TXIE      7
`define SCE_SR_FAULT     1
`define SCE_SR_RXF       5
`define SCE_SR_DONE      6
`define SCE_SR_TBE       7
`define SCE_DH_T9        0
`define SCE_DH_R9        7

`define SCE_RST_CR       8'h00
`define SCE_RST_TBE      1'b1

`define SCE_RT_PER_BIT   16
`define SCE_LOAD_RT      9
`define SCE_RX_SAMP_RT   8
`define SCE_LEN_8        4'hA
`define SCE_LEN_9        4'hB
`define SCE_LEN_LBRK_8   4'hD
`define SCE_LEN_LBRK_9   4'hE
`define SCE_LEN_TAIL     4'h1

`endif

// >>> logic/sce_pkg.sv
// Purpose: types of the serial character engine
// Assumes: constants live in sce_consts.svh
// Notes:   none
`default_nettype none

package sce_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sce_bus_s;

  typedef enum logic {RX_IDLE, RX_RUN} sce_rx_e;

endpackage

`default_nettype wire

// >>> logic/sce_top.sv
// Purpose: async serial character transmitter and receiver
// Assumes: one clock, register port answers one cycle after read
// Notes:   receiver takes one sample per bit, no noise voting
// Notes on behaviour
// - shift buffered character out framed
// - set buffer-empty flag on each transfer
// - buffer-empty flag is set after reset
// - no new frame until flag cleared
// - transfer next character 9/16 into stop
// - enable rise sends preamble of ones
// - start bit low at lsb, stop high
// - odd or even parity in msb
// - transmit irq while empty and enabled
// - line idles high between frames
// - disabling mid frame finishes frame
// - disable then enable queues idle character
// - break writes zero character, no framing
// - break repeats, then at least one one
// - received break sets flags, clears data
// - idle character is all ones
// - release pin when disabled and done
// - receive 8 or 9 bits, ninth high
// - receive full flag and its irq
// - zero divisor stops baud, low commits
// - long break selects 13 or 14 bits
// - 13-bit divider, transmit is divide 16
`timescale 1ns/100ps
`default_nettype none
`include "sce_consts.svh"

module sce_top #(
  parameter int unsigned DIV_W = 13
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire sce_pkg::sce_bus_s bus_in,
  output logic [7:0]            rdata_out,
  input  wire logic             rxd_in,
  output logic                  txd_out,
  output logic                  txd_oe_out,
  output logic                  tx_irq_out,
  output logic                  rx_irq_out
);

  // register decode
  wire wr_bdh = bus_in.wr && (bus_in.addr == `SCE_OFF_BDH);
  wire wr_bdl = bus_in.wr && (bus_in.addr == `SCE_OFF_BDL);
  wire wr_cr1 = bus_in.wr && (bus_in.addr == `SCE_OFF_CR1);
  wire wr_cr2 = bus_in.wr && (bus_in.addr == `SCE_OFF_CR2);
  wire wr_dh  = bus_in.wr && (bus_in.addr == `SCE_OFF_DH);
  wire wr_dl  = bus_in.wr && (bus_in.addr == `SCE_OFF_DL);
  wire rd_sr1 = bus_in.rd && (bus_in.addr == `SCE_OFF_SR1);
  wire rd_dl  = bus_in.rd && (bus_in.addr == `SCE_OFF_DL);

  logic [DIV_W-1:0] sbr_r;
  logic [DIV_W-9:0] sbr_hi_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic [7:0]       cr1_r;
  logic [7:0]       cr2_r;
  logic [7:0]       dl_r;
  logic             t9_r;

  wire char9      = cr1_r[`SCE_C1_CHAR9];
  wire par_on     = cr1_r[`SCE_C1_PAR];
  wire par_odd    = cr1_r[`SCE_C1_PTYPE];
  wire long_break_sel = cr1_r[`SCE_C1_LBRK];
  wire send_break_ctl = cr2_r[`SCE_C2_BRK];
  wire tx_on      = cr2_r[`SCE_C2_TXON];
  wire rx_on      = cr2_r[`SCE_C2_RXON];
  wire tx_empty_irq_on = cr2_r[`SCE_C2_TXIE];
  wire rx_full_irq_on  = cr2_r[`SCE_C2_RXIE];

  // baud divider: one enable pulse per rt clock, 16 per bit
  wire div_on  = (sbr_r != '0);
  wire rt_tick = div_on && (div_cnt_r == sbr_r - DIV_W'(1));

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sbr_r    <= '0;
      sbr_hi_r <= '0;
    end else if (wr_bdh) begin
      sbr_hi_r <= bus_in.wdata[DIV_W-9:0];
    end else if (wr_bdl) begin
      sbr_r    <= {sbr_hi_r, bus_in.wdata};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= '0;
    end else if (!div_on || rt_tick) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cr1_r <= `SCE_RST_CR;
      cr2_r <= `SCE_RST_CR;
      dl_r  <= 8'h00;
      t9_r  <= 1'b0;
    end else begin
      if (wr_cr1) cr1_r <= bus_in.wdata;
      if (wr_cr2) cr2_r <= bus_in.wdata;
      if (wr_dl)  dl_r  <= bus_in.wdata;
      if (wr_dh)  t9_r  <= bus_in.wdata[`SCE_DH_T9];
    end
  end

  // transmitter state
  logic [13:0] tx_sh_r;
  logic [3:0]  tx_left_r;
  logic [3:0]  tx_sub_r;
  logic [13:0] nx_sh_r;
  logic [3:0]  nx_len_r;
  logic        nx_v_r;
  logic        nx_data_r;
  logic        pre_pend_r;
  logic        brk_tail_r;
  logic        tx_on_d_r;
  logic        tx_buffer_empty_flag_r;
  logic        tbe_arm_r;

  wire tx_busy  = (tx_left_r != 4'h0);
  wire tx_done_flag = !tx_busy && !nx_v_r;
  wire tx_rise  = tx_on && !tx_on_d_r;
  wire [3:0] len_char = char9 ? `SCE_LEN_9 : `SCE_LEN_8;
  wire [3:0] len_lbrk = char9 ? `SCE_LEN_LBRK_9 : `SCE_LEN_LBRK_8;
  wire [3:0] len_brk  = long_break_sel ? len_lbrk : len_char;

  // parity: even gives an even count of ones
  wire par_bit = (char9 ? ^dl_r : ^dl_r[6:0]) ^ par_odd;
  wire bit7    = (!char9 && par_on) ? par_bit : dl_r[7];
  wire bit8    = par_on ? par_bit : t9_r;
  // upper fill is ones so a short frame leaves the line high
  wire [13:0] frame8 = {4'hF, 1'b1, bit7, dl_r[6:0], 1'b0};
  wire [13:0] frame9 = {3'h7, 1'b1, bit8, dl_r, 1'b0};
  wire [13:0] frame  = char9 ? frame9 : frame8;

  // the next character is chosen 9/16 into the stop bit
  wire at_load  = (tx_left_r == 4'h1) && rt_tick &&
                  (tx_sub_r == 4'(`SCE_LOAD_RT - 1));
  wire slot     = !nx_v_r && (!tx_busy || at_load);
  wire pick_pre = slot && tx_on && pre_pend_r;
  wire pick_brk = slot && tx_on && !pre_pend_r && send_break_ctl;
  wire pick_tail = slot && !pick_pre && !pick_brk && brk_tail_r;
  wire pick_data = slot && tx_on && !pre_pend_r && !send_break_ctl &&
                   !brk_tail_r && !tx_buffer_empty_flag_r;
  wire pick_any = pick_pre || pick_brk || pick_tail || pick_data;
  wire [13:0] pick_sh = pick_data ? frame :
                        pick_brk  ? 14'h0000 : 14'h3FFF;
  wire [3:0] pick_len = (pick_data || pick_pre) ? len_char :
                        pick_brk ? len_brk : `SCE_LEN_TAIL;

  wire shift_evt = tx_busy && rt_tick &&
                   (tx_sub_r == 4'(`SCE_RT_PER_BIT - 1));
  wire ld_sh = nx_v_r && ((shift_evt && tx_left_r == 4'h1) ||
                          (!tx_busy && rt_tick));

  wire tbe_clr = wr_dl && tbe_arm_r;
  wire tbe_nxt = pick_data || (tx_buffer_empty_flag_r && !tbe_clr);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_r   <= 14'h3FFF;
      tx_left_r <= 4'h0;
      tx_sub_r  <= 4'h0;
    end else if (ld_sh) begin
      tx_sh_r   <= nx_sh_r;
      tx_left_r <= nx_len_r;
      tx_sub_r  <= 4'h0;
    end else if (shift_evt) begin
      tx_sh_r   <= {1'b1, tx_sh_r[13:1]};
      tx_left_r <= tx_left_r - 4'h1;
      tx_sub_r  <= 4'h0;
    end else if (tx_busy && rt_tick) begin
      tx_sub_r  <= tx_sub_r + 4'h1;
    end
  end

  // a clear enable stops new picks except the break tail, a frame in flight still runs out
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nx_v_r    <= 1'b0;
      nx_sh_r   <= 14'h3FFF;
      nx_len_r  <= 4'h0;
      nx_data_r <= 1'b0;
    end else if (pick_any) begin
      nx_v_r    <= 1'b1;
      nx_sh_r   <= pick_sh;
      nx_len_r  <= pick_len;
      nx_data_r <= pick_data;
    end else if (ld_sh) begin
      nx_v_r    <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_pend_r <= 1'b0;
      brk_tail_r <= 1'b0;
      tx_on_d_r  <= 1'b0;
    end else begin
      tx_on_d_r <= tx_on;
      if (tx_rise) pre_pend_r <= 1'b1;
      else if (pick_pre) pre_pend_r <= 1'b0;
      if (pick_brk) brk_tail_r <= 1'b1;
      else if (pick_tail) brk_tail_r <= 1'b0;
    end
  end

  // empty flag: a status read arms the clear, a low data write fires it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_buffer_empty_flag_r <= `SCE_RST_TBE;
      tbe_arm_r <= 1'b0;
    end else begin
      tx_buffer_empty_flag_r <= tbe_nxt;
      if (wr_dl) tbe_arm_r <= 1'b0;
      else if (rd_sr1 && tx_buffer_empty_flag_r) tbe_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      txd_out    <= 1'b1;
      txd_oe_out <= 1'b0;
      tx_irq_out <= 1'b0;
    end else begin
      txd_out    <= tx_busy ? tx_sh_r[0] : 1'b1;
      txd_oe_out <= tx_on || !tx_done_flag;
      tx_irq_out <= tbe_nxt && tx_empty_irq_on;
    end
  end

  // receiver: two-stage synchroniser, third stage for the edge
  logic rx_m1_r;
  logic rx_m2_r;
  logic rx_m3_r;
  sce_pkg::sce_rx_e rx_st_r;
  logic [3:0] rx_sub_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [7:0] rx_data_r;
  logic       rx_ninth_bit_r;
  logic       rx_full_flag_r;
  logic       frame_fault_flag_r;
  logic       rxf_arm_r;

  wire rx_fall  = rx_m3_r && !rx_m2_r;
  wire rx_run   = (rx_st_r == sce_pkg::RX_RUN);
  wire samp     = rx_run && rt_tick &&
                  (rx_sub_r == 4'(`SCE_RX_SAMP_RT - 1));
  wire [3:0] rx_last = len_char - 4'h1;
  wire bad_start = samp && (rx_bit_r == 4'h0) && rx_m2_r;
  wire rx_done  = samp && (rx_bit_r == rx_last);
  wire [7:0] rx_word = char9 ? rx_sh_r[7:0] : rx_sh_r[8:1];
  wire rx_nine  = char9 && rx_sh_r[8];
  wire rx_brk   = rx_done && !rx_m2_r && (rx_word == 8'h00) && !rx_nine;
  wire rxf_clr  = rd_dl && rxf_arm_r;
  wire rxf_nxt  = rx_done || (rx_full_flag_r && !rxf_clr);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_m1_r <= 1'b1;
      rx_m2_r <= 1'b1;
      rx_m3_r <= 1'b1;
    end else begin
      rx_m1_r <= rxd_in;
      rx_m2_r <= rx_m1_r;
      rx_m3_r <= rx_m2_r;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_r  <= sce_pkg::RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r  <= 9'h000;
    end else begin
      case (rx_st_r)
        sce_pkg::RX_IDLE: begin
          rx_sub_r <= 4'h0;
          rx_bit_r <= 4'h0;
          if (rx_on && rx_fall) rx_st_r <= sce_pkg::RX_RUN;
        end
        sce_pkg::RX_RUN: begin
          if (rt_tick) rx_sub_r <= rx_sub_r + 4'h1;
          if (bad_start || rx_done) begin
            rx_st_r <= sce_pkg::RX_IDLE;
          end else if (samp) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r != 4'h0) rx_sh_r <= {rx_m2_r, rx_sh_r[8:1]};
          end
        end
        default: rx_st_r <= sce_pkg::RX_IDLE;
      endcase
    end
  end

  // full flag: a status read arms the clear, a low data read fires it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_data_r          <= 8'h00;
      rx_ninth_bit_r     <= 1'b0;
      rx_full_flag_r     <= 1'b0;
      frame_fault_flag_r <= 1'b0;
      rxf_arm_r          <= 1'b0;
      rx_irq_out         <= 1'b0;
    end else begin
      rx_full_flag_r <= rxf_nxt;
      rx_irq_out     <= rxf_nxt && rx_full_irq_on;
      if (rx_done) begin
        rx_data_r          <= rx_brk ? 8'h00 : rx_word;
        rx_ninth_bit_r     <= rx_brk ? 1'b0 : rx_nine;
        frame_fault_flag_r <= !rx_m2_r;
      end else if (rxf_clr) begin
        frame_fault_flag_r <= 1'b0;
      end
      if (rd_dl) rxf_arm_r <= 1'b0;
      else if (rd_sr1 && rx_full_flag_r) rxf_arm_r <= 1'b1;
    end
  end

  // read path
  wire [7:0] sr1 = (8'(tx_buffer_empty_flag_r) << `SCE_SR_TBE) |
                   (8'(tx_done_flag) << `SCE_SR_DONE) |
                   (8'(rx_full_flag_r) << `SCE_SR_RXF) |
                   (8'(frame_fault_flag_r) << `SCE_SR_FAULT);
  wire [7:0] rd_mux =
    (bus_in.addr == `SCE_OFF_BDH) ? 8'(sbr_r >> 8) :
    (bus_in.addr == `SCE_OFF_BDL) ? sbr_r[7:0] :
    (bus_in.addr == `SCE_OFF_CR1) ? cr1_r :
    (bus_in.addr == `SCE_OFF_CR2) ? cr2_r :
    (bus_in.addr == `SCE_OFF_SR1) ? sr1 :
    (bus_in.addr == `SCE_OFF_DH)  ? 8'(rx_ninth_bit_r) << `SCE_DH_R9 :
    (bus_in.addr == `SCE_OFF_DL)  ? rx_data_r : 8'h00;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) rdata_out <= 8'h00;
    else rdata_out <= bus_in.rd ? rd_mux : 8'h00;
  end

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_data_ld;
    ld_sh && nx_data_r;
  endsequence

  sequence s_start_out;
    (tx_sh_r[0] == 1'b0) && (tx_left_r == len_char) ##1 !txd_out;
  endsequence

  tbe_on_pick_a: assert property (
    pick_data |=> tx_buffer_empty_flag_r && nx_v_r)
    else $error("empty flag not set on transfer");

  no_early_load_a: assert property (
    (tx_buffer_empty_flag_r && !tbe_clr) |=> !pick_data)
    else $error("frame picked while buffer empty");

  load_point_a: assert property (
    (pick_data && tx_busy) |-> tx_left_r == 4'h1 &&
      tx_sub_r == 4'(`SCE_LOAD_RT - 1))
    else $error("transfer not at 9/16 of stop bit");

  start_bit_a: assert property (
    s_data_ld |=> s_start_out)
    else $error("start bit not low");

  preamble_a: assert property (
    $rose(tx_on) |=> pre_pend_r)
    else $error("preamble not queued");

  idle_high_a: assert property (
    !tx_busy |=> txd_out)
    else $error("line not idle high");

  pin_release_a: assert property (
    (!tx_on && tx_done_flag) |=> !txd_oe_out)
    else $error("pin still driven");

  tx_irq_a: assert property (
    $rose(tx_buffer_empty_flag_r) && tx_empty_irq_on |-> tx_irq_out)
    else $error("transmit irq missing");

  baud_hold_a: assert property (
    wr_bdh |=> $stable(sbr_r))
    else $error("high divisor took effect alone");

  baud_off_a: assert property (
    !div_on |-> !rt_tick ##1 div_cnt_r == '0)
    else $error("divider ran at zero");

  rx_break_a: assert property (
    rx_brk |=> frame_fault_flag_r && rx_full_flag_r &&
      rx_data_r == 8'h00)
    else $error("break not flagged");

  rx_full_a: assert property (
    $rose(rx_full_flag_r) && rx_full_irq_on |-> rx_irq_out)
    else $error("receive irq missing");

endmodule

`default_nettype wire

// >>> testbench/sce_remote.sv
// Purpose: remote serial device on the far side of the line
// Assumes: one bit lasts BIT_CLKS clocks, frames lsb first
// Notes:   decodes every frame seen into rx_q, sends frames on request
`timescale 1ns/100ps
`default_nettype none

module sce_remote #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  input  wire logic nine_in,
  output var  logic rxd_out
);
  logic [9:0] rx_q[$];
  logic [9:0] v;
  int         k;

  initial rxd_out = 1'b1;

  // bit k lands in v[k]; the stop bit follows the data, unused bits stay 1
  initial begin
    forever begin
      @(posedge clk_in);
      if (line_in === 1'b0) begin
        v = '1;
        repeat (BIT_CLKS / 2) @(posedge clk_in);
        for (k = 0; k <= 8 + nine_in; k++) begin
          repeat (BIT_CLKS) @(posedge clk_in);
          v[k] = line_in;
        end
        rx_q.push_back(v);
        // a break leaves the line low past its stop position
        for (k = 0; k < 4000 && line_in !== 1'b1; k++) @(posedge clk_in);
      end
    end
  end

  // 8-bit frames carry one spare idle bit at the end
  task automatic send(input logic [8:0] d, input logic stop);
    int          i;
    logic [10:0] f;
    f = nine_in ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    for (i = 0; i < 11; i++) begin
      rxd_out <= f[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
  endtask

endmodule
`default_nettype wire

// >>> testbench/test_sce_top.sv
// Purpose: self-checking bench of the serial character engine
// Assumes: divisor 1, so one bit lasts 16 clocks
// Notes:   every wait is bounded; the released line is pulled up
`timescale 1ns/100ps
`default_nettype none
`include "sce_consts.svh"

module test_sce_top;
  localparam int BIT = 16;
  localparam logic [2:0] BDH = `SCE_OFF_BDH;
  localparam logic [2:0] BDL = `SCE_OFF_BDL;
  localparam logic [2:0] CR1 = `SCE_OFF_CR1;
  localparam logic [2:0] CR2 = `SCE_OFF_CR2;
  localparam logic [2:0] SR  = `SCE_OFF_SR1;
  localparam logic [2:0] DH  = `SCE_OFF_DH;
  localparam logic [2:0] DL  = `SCE_OFF_DL;

  logic              clk_in;
  logic              rst_n_in;
  sce_pkg::sce_bus_s bus;
  logic [7:0]        rdata;
  logic              txd, txd_oe, tx_irq, rx_irq, rxd, nine;
  wire logic         tx_line;
  logic [7:0]        r;
  logic [9:0]        v;
  int                errors, checks_done, n, p, t0, t1;
  int                cyc = 0;

  assign tx_line = txd_oe ? txd : 1'b1;

  sce_top #(.DIV_W(13)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
    .rdata_out(rdata), .rxd_in(rxd), .txd_out(txd),
    .txd_oe_out(txd_oe), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));

  sce_remote #(.BIT_CLKS(BIT)) remote (
    .clk_in(clk_in), .line_in(tx_line), .nine_in(nine), .rxd_out(rxd));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  always @(posedge clk_in) cyc <= cyc + 1;

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic stuck();
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_rng(input int g, input int lo, input int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      errors++;
      $display("[FAIL] %0t count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    @(posedge clk_in);
    // data launched one edge ago, still standing before this edge updates
    d = rdata;
  endtask

  function automatic logic probe(input int w);
    case (w)
      0:       probe = tx_line;
      1:       probe = tx_irq;
      2:       probe = rx_irq;
      default: probe = txd_oe;
    endcase
  endfunction

  // returns one step after the edge at which the level is seen
  task automatic wait_for(input int w, input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge clk_in);
      #1;
      c++;
    end while (probe(w) !== lvl && c < 5000);
    if (c >= 5000) stuck();
  endtask

  task automatic pop(output logic [9:0] x);
    int c;
    for (c = 0; c < 5000 && remote.rx_q.size() == 0; c++) @(posedge clk_in);
    if (c >= 5000) stuck();
    x = remote.rx_q.pop_front();
  endtask

  initial begin
    #(8 * 100000);
    stuck();
  end

  initial begin
    bus = '0;
    nine = 1'b0;
    rst_n_in = 1'b0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    chk(10'(txd), 10'h1);
    chk(10'(txd_oe), 10'h0);
    chk(10'(tx_irq), 10'h0);
    rd(SR, r);
    chk(10'(r[7]), 10'h1);
    rd(3'h5, r);
    chk(10'(r), 10'h000);
    wr(BDL, 8'h01);
    wr(BDH, 8'h1F);
    wr(CR1, 8'h00);
    wr(CR2, 8'h88);
    t0 = cyc;
    wait_for(1, 1'b1, n);
    chk_rng(n, 1, 3);
    rd(SR, r);
    wr(DL, 8'h5A);
    wait_for(1, 1'b1, n);
    rd(SR, r);
    wr(DL, 8'hC3);
    wait_for(0, 1'b0, n);
    t1 = cyc;
    chk_rng(t1 - t0, 10 * BIT - 4, 10 * BIT + 20);
    wait_for(1, 1'b1, n);
    chk_rng(cyc - t1, 9 * BIT + 6, 9 * BIT + 13);
    pop(v);
    chk(v, 10'h35A);
    pop(v);
    chk(v, 10'h3C3);
    // the flag is up but never cleared: nothing more may go out
    repeat (400) @(posedge clk_in);
    chk_rng(remote.rx_q.size(), 0, 0);
    chk(10'(tx_line), 10'h1);
    rd(SR, r);
    wr(DL, 8'h00);
    wait_for(0, 1'b0, n);
    t1 = cyc;
    wr(CR2, 8'h80);
    wr(CR2, 8'h88);
    rd(SR, r);
    wr(DL, 8'h81);
    pop(v);
    chk(v, 10'h300);
    wait_for(0, 1'b0, n);
    chk_rng(cyc - t1, 20 * BIT - 2, 20 * BIT + 18);
    pop(v);
    chk(v, 10'h381);
    rd(SR, r);
    wr(DL, 8'h3C);
    wait_for(0, 1'b0, n);
    wr(CR2, 8'h00);
    pop(v);
    chk(v, 10'h33C);
    wait_for(3, 1'b0, n);
    chk_rng(n, 1, BIT);
    rd(SR, r);
    chk(10'(r[6]), 10'h1);
    for (p = 0; p < 2; p++) begin
      wr(CR1, 8'(2 + p));
      wr(CR2, 8'h08);
      rd(SR, r);
      wr(DL, 8'h07);
      pop(v);
      chk(v, {2'b11, ~p[0], 7'h07});
      wr(CR2, 8'h00);
      wait_for(3, 1'b0, n);
    end
    nine = 1'b1;
    wr(CR1, 8'h10);
    wr(CR2, 8'h2C);
    wr(DH, 8'h01);
    rd(SR, r);
    wr(DL, 8'hA5);
    pop(v);
    chk(v, 10'h3A5);
    remote.send(9'h1C3, 1'b1);
    wait_for(2, 1'b1, n);
    rd(SR, r);
    chk(10'(r[5]), 10'h1);
    rd(DH, r);
    chk(10'(r[7]), 10'h1);
    rd(DL, r);
    chk(10'(r), 10'h0C3);
    wait_for(2, 1'b0, n);
    chk_rng(n, 1, 3);
    nine = 1'b0;
    wr(CR1, 8'h00);
    remote.send(9'h000, 1'b0);
    wait_for(2, 1'b1, n);
    rd(SR, r);
    chk(10'(r & 8'h22), 10'h022);
    rd(DH, r);
    chk(10'(r[7]), 10'h0);
    rd(DL, r);
    chk(10'(r), 10'h000);
    for (p = 0; p < 2; p++) begin
      wr(CR1, 8'(p * 8));
      wr(CR2, 8'h0D);
      wait_for(0, 1'b0, n);
      t1 = cyc;
      wr(CR2, 8'h00);
      wait_for(0, 1'b1, n);
      chk_rng(cyc - t1, (10 + 3 * p) * BIT - 2,
              (10 + 3 * p) * BIT + 2);
      wait_for(3, 1'b0, n);
      chk_rng(n, BIT - 2, BIT + 4);
      pop(v);
      chk(v, 10'h200);
    end
    tally_and_finish();
  end

endmodule
`default_nettype wire
